// [rtl/pusl_top.sv]
`timescale 1ns/1ps

module pusl_top
  import pusl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [1:0]  config_base_select,
  input  wire logic [1:0]  environment_select,
  input  wire logic        shared_bios_strap,
  input  wire logic        float_all_strap,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             strap_pulldown_en,
  output logic             straps_valid,
  output logic [7:0]       config_index_addr,
  output logic [7:0]       config_data_addr,
  output pusl_env_t        operating_env,
  output logic             shared_bios_active,
  output logic             float_all_pins,
  output logic             env_conflict
);

  // ==========================================================
  // strap capture
  pusl_strap_if st ();

  assign st.raw = {float_all_strap, shared_bios_strap,
                   environment_select, config_base_select};

  pusl_latch u_latch
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .st      (st)
  );

  wire logic [1:0] base_held  = st.held[BASE_LSB +: 2];
  wire logic [1:0] env_held   = st.held[ENV_LSB +: 2];
  wire logic       shared_bios_strap_held  = st.held[SHARED_BIOS_STRAP_BIT];
  wire logic       float_held = st.held[FLOAT_BIT];

  // ==========================================================
  // settings derived from the caught straps
  logic [7:0]  index_q;
  logic        float_q;
  logic        share_q;
  pusl_env_t   env_q;

  wire logic [7:0] index_d   = base_held[0] ? CFG_INDEX_HIGH
                                            : CFG_INDEX_LOW;
  wire pusl_env_t  env_d     = pusl_env_t'(env_held);
  wire logic       float_env = (env_d == PUSL_IN_SYSTEM_EMULATION_ENV) ||
                               (env_d == PUSL_ON_BOARD_DEBUG_ENV);
  wire logic       float_d   = st.done && float_held &&
                               float_env;
  logic            ctl_share_q;
  wire logic       share_d   = st.done && shared_bios_strap_held &&
                               ctl_share_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      index_q <= CFG_INDEX_LOW;
      env_q   <= PUSL_IN_SYSTEM_EMULATION_ENV;
      float_q <= 1'b0;
      share_q <= 1'b0;
    end
    else
    begin
      index_q <= index_d;
      env_q   <= env_d;
      float_q <= float_d;
      share_q <= share_d;
    end
  end

  assign strap_pulldown_en  = !st.done;
  assign straps_valid       = st.done;
  assign config_index_addr  = index_q;
  assign config_data_addr   = index_q + CFG_DATA_STEP;
  assign operating_env      = env_q;
  assign shared_bios_active = share_q;
  assign float_all_pins     = float_q;
  assign env_conflict       = st.done &&
                              (env_q == PUSL_PROGRAMMING_ENV);

  // ==========================================================
  // apb slave, read data latched in the setup cycle, no wait states
  wire logic setup     = psel && !penable;
  wire logic access    = psel && penable;
  wire logic hit_stat  = (paddr == STATUS_OFS);
  wire logic hit_ctl   = (paddr == CONTROL_OFS);
  wire logic hit_ports = (paddr == PORTS_OFS);
  wire logic mapped    = hit_stat || hit_ctl || hit_ports;
  wire logic ctl_wr    = access && pwrite && hit_ctl;

  wire logic [31:0] stat_word =
    (32'(st.held) << ST_STRAP_LSB) |
    (32'(float_q) << ST_FLOAT_ACT) |
    (32'(st.done) << ST_DONE) |
    (32'(env_conflict) << ST_ENV_BAD);
  wire logic [31:0] ctl_word  = 32'(ctl_share_q) << CT_SHARE_EN;
  wire logic [31:0] port_word = (32'(config_index_addr) << PT_INDEX_LSB) |
                                (32'(config_data_addr) << PT_DATA_LSB);
  wire logic [31:0] rd_mux    = hit_stat  ? stat_word :
                                hit_ctl   ? ctl_word  :
                                hit_ports ? port_word : 32'h0000_0000;

  logic [31:0] prdata_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata_q    <= 32'h0000_0000;
      ctl_share_q <= CT_SHARE_RST;
    end
    else
    begin
      if (setup)
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      if (ctl_wr)
        ctl_share_q <= pwdata[CT_SHARE_EN];
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = access && !mapped;

  // ==========================================================
  // checks
  base_pair_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(st.done) |=> config_index_addr ==
      ($past(config_base_select[0], 2) ? 8'h4e : 8'h2e) &&
      config_data_addr == config_index_addr + 8'h01)
    else $error("config port base does not follow strap");

  port_read_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    psel && !penable && !pwrite && paddr == PORTS_OFS |=>
      prdata[15:0] == {$past(config_data_addr), $past(config_index_addr)})
    else $error("port read does not show config addresses");

  env_map_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(st.done) |=>
      operating_env == pusl_env_t'($past(environment_select, 2)))
    else $error("environment does not follow strap");

  share_map_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    st.done && ctl_share_q ##1 st.done |->
      shared_bios_active == $past(shared_bios_strap_held))
    else $error("shared bios does not follow strap");

  share_off_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !shared_bios_strap_held |=> !shared_bios_active)
    else $error("shared bios on with strap low");

  ctl_write_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    psel && penable && pwrite && paddr == CONTROL_OFS |=>
      ctl_share_q == $past(pwdata[CT_SHARE_EN]))
    else $error("control write did not land");

  float_map_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    st.done && float_held && !env_held[0] |=> float_all_pins)
    else $error("float strap did not float pins");

  float_off_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !float_held || !st.done |=> !float_all_pins)
    else $error("pins floated without a caught float strap");

  float_env_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    float_all_pins |-> operating_env == PUSL_IN_SYSTEM_EMULATION_ENV ||
      operating_env == PUSL_ON_BOARD_DEBUG_ENV)
    else $error("float active outside debug environments");

  hold_stable_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    st.done [*3] |-> $stable(st.held) && $stable(config_index_addr) &&
      $stable(operating_env))
    else $error("caught straps changed after capture");

  capture_once_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !st.done |=> st.done && st.held == $past(st.raw))
    else $error("straps not caught at first edge");

  status_read_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    psel && !penable && !pwrite && paddr == STATUS_OFS |=>
      prdata[5:0] == $past(st.held) && prdata[7] == $past(st.done))
    else $error("status read does not show caught straps");

  pulldown_end_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(st.done) |-> !strap_pulldown_en [*3])
    else $error("pull-downs still active after capture");

endmodule

// [rtl/pusl_pkg.sv]
package pusl_pkg;

  // ==========================================================
  // strap vector layout
  localparam int unsigned STRAP_W       = 6;
  localparam int unsigned BASE_LSB      = 0;
  localparam int unsigned ENV_LSB       = 2;
  localparam int unsigned SHARED_BIOS_STRAP_BIT      = 4;
  localparam int unsigned FLOAT_BIT     = 5;

  // ==========================================================
  // configuration index/data port bases
  localparam logic [7:0] CFG_INDEX_LOW  = 8'h2e;
  localparam logic [7:0] CFG_INDEX_HIGH = 8'h4e;
  localparam logic [7:0] CFG_DATA_STEP  = 8'h01;

  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [11:0] STATUS_OFS    = 12'h000;
  localparam logic [11:0] CONTROL_OFS   = 12'h004;
  localparam logic [11:0] PORTS_OFS     = 12'h008;

  // status fields
  localparam int unsigned ST_STRAP_LSB  = 0;
  localparam int unsigned ST_FLOAT_ACT  = 6;
  localparam int unsigned ST_DONE       = 7;
  localparam int unsigned ST_ENV_BAD    = 8;

  // control fields
  localparam int unsigned CT_SHARE_EN   = 0;
  localparam logic        CT_SHARE_RST  = 1'b1;

  // ports fields
  localparam int unsigned PT_INDEX_LSB  = 0;
  localparam int unsigned PT_DATA_LSB   = 8;

  // ==========================================================
  // operating environments, bit 0 is the first environment strap
  typedef enum logic [1:0] {
    PUSL_IN_SYSTEM_EMULATION_ENV = 2'h0,
    PUSL_DEVELOPMENT_ENV         = 2'h1,
    PUSL_ON_BOARD_DEBUG_ENV      = 2'h2,
    PUSL_PROGRAMMING_ENV         = 2'h3
  } pusl_env_t;

endpackage

// [rtl/pusl_strap_if.sv]
`timescale 1ns/1ps
interface pusl_strap_if;
  import pusl_pkg::*;

  logic [STRAP_W-1:0] raw;
  logic [STRAP_W-1:0] held;
  logic               done;

  modport latch
  (
    input  raw,
    output held,
    output done
  );

  modport user
  (
    output raw,
    input  held,
    input  done
  );
endinterface

// [rtl/pusl_latch.sv]
`timescale 1ns/1ps
module pusl_latch
  import pusl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  pusl_strap_if.latch st
);

  logic [STRAP_W-1:0] held_q;
  logic               done_q;

  // ==========================================================
  // capture once at the first edge after reset release
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      held_q <= '0;
      done_q <= 1'b0;
    end
    else if (!done_q)
    begin
      held_q <= st.raw;
      done_q <= 1'b1;
    end
  end

  assign st.held = held_q;
  assign st.done = done_q;

endmodule

// [bench/pusl_pullup_model.sv]
`timescale 1ns/1ps
// ==========================================================
// strap pins: internal pull-downs during reset, fitted pull-ups
module pusl_pullup_model
(
  input  wire logic       sys_clk,
  input  wire logic       pulldown_en,
  input  wire logic [5:0] fitted,
  output logic [5:0]      strap
);
  logic [5:0] drift_q = 6'h15;
  // undriven pins wander once the pull-downs let go
  always @(posedge sys_clk)
    drift_q <= ~drift_q;
  // fitted pull-up reads 1, else 0 while pull-down is on
  assign strap = fitted | ({6{~pulldown_en}} & drift_q);
endmodule

// [bench/test_power_up_strap_latch.sv]
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("[ERR] t=%0t got %h exp %h", $time, a, b); \
    end \
  end
module test_power_up_strap_latch
  import pusl_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [5:0]  fit = 6'h00;
  logic [5:0]  strap;
  logic        pready, pslverr, pd_en, valid, shared, flt, conflict;
  logic [31:0] prdata, r;
  logic [7:0]  idx, dat;
  logic        e;
  pusl_env_t   env;
  int          miscompares = 0;
  int          checks = 0;

  always #5 sys_clk = ~sys_clk;

  pusl_pullup_model pu (.sys_clk(sys_clk), .pulldown_en(pd_en),
    .fitted(fit), .strap(strap));
  pusl_top dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .config_base_select(strap[1:0]), .environment_select(strap[3:2]),
    .shared_bios_strap(strap[4]), .float_all_strap(strap[5]),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .strap_pulldown_en(pd_en), .straps_valid(valid),
    .config_index_addr(idx), .config_data_addr(dat),
    .operating_env(env), .shared_bios_active(shared),
    .float_all_pins(flt), .env_conflict(conflict));

  // ==========================================================
  // bus and reset helpers
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // env pattern 11 is never fitted on the board
  task automatic boot(input logic [5:0] f);
    repeat (2) @(posedge sys_clk);
    fit <= f;
    arst_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    `CHK(pd_en, 1'b1)
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(valid, 1'b1)
    `CHK(pd_en, 1'b0)
  endtask

  // ==========================================================
  // scenarios
  task automatic t_base();
    for (int b = 0; b < 3; b++)
    begin
      boot(6'(b));
      `CHK(idx, b[0] ? 8'h4e : 8'h2e)
      `CHK(dat, b[0] ? 8'h4f : 8'h2f)
    end
  endtask

  task automatic t_env_float();
    for (int v = 0; v < 6; v++)
    begin
      boot({v[0], 1'b0, 2'(v >> 1), 2'b00});
      `CHK(env, pusl_env_t'(2'(v >> 1)))
      `CHK(flt, v[0] & (v >> 1 != 1))
      `CHK(conflict, 1'b0)
    end
  endtask

  task automatic t_share();
    boot(6'h00);
    `CHK(shared, 1'b0)
    boot(6'h10);
    `CHK(shared, 1'b1)
    apb(1'b1, CONTROL_OFS, 32'h0);
    apb(1'b0, CONTROL_OFS, 32'h0);
    `CHK(r[0], 1'b0)
    #1;
    `CHK(shared, 1'b0)
  endtask

  task automatic t_hold();
    boot(6'h15);
    fit <= 6'h2a;
    repeat (20) @(posedge sys_clk);
    apb(1'b1, STATUS_OFS, 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(r[8:0], 9'h095)
    apb(1'b0, PORTS_OFS, 32'h0);
    `CHK(r[15:0], 16'h4f4e)
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK(e, 1'b1)
    #1;
    `CHK(env, PUSL_DEVELOPMENT_ENV)
    `CHK(idx, 8'h4e)
  endtask

  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    t_base();
    t_env_float();
    t_share();
    t_hold();
    report_and_stop();
  end

  initial
  begin
    #20000;
    miscompares++;
    report_and_stop();
  end
endmodule
